// file: hdl/pcio_top.sv
// port 3 fixed-direction port with comparators, ahb-lite registers
//
// Behaviour
// - eight-bit port: four fixed inputs low, four fixed outputs high, never turned.
// - inputs are plain cmos inputs; outputs four to seven always driven push-pull.
// - input edges raise interrupts; outputs may carry counter/timer signals instead.
// - analog mode: inputs a and b feed comparators, reference from in3 and aux pin.
// - analog mode: in3 latch and irq_line_one go to stop recovery; comparators excluded.
// - digital mode: in3 reads as bit three and raises irq_line_one.
// - comparators are powered down whenever stop mode is entered.
// - port_config_reg can steer comparator results onto outputs four and seven.
`default_nettype none
`include "pcio_consts.svh"
module pcio_top #(
	parameter int NUM_IN = 4
) (
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	input  wire logic                 hsel,
	input  wire logic [7:0]           haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic      [31:0]          hrdata,
	output logic                      hreadyout,
	output logic                      hresp,
	input  wire logic [3:0]           port3_in,
	input  wire logic                 reference_pin_aux,
	input  wire logic                 comp_a_result,
	input  wire logic                 comp_b_result,
	input  wire logic                 stop_mode,
	input  wire logic [3:0]           timer_out,
	output logic      [3:0]           port3_out,
	output logic                      comp_power_en,
	output logic                      irq_line_one,
	output logic                      stop_rec_in3,
	output logic                      stop_rec_irq_line_one,
	output logic                      stop_rec_comp_en,
	output logic                      irq
);
	import pcio_pkg::*;

	logic [3:0]             data_out_ff;
	pcio_cfg_s              cfg_ff;
	logic [`PCIO_EVT_W-1:0] status_ff;
	logic [`PCIO_EVT_W-1:0] mask_ff;
	pcio_acc_s              acc_ff;
	logic [31:0]            hrdata_ff;
	logic                   hreadyout_ff;
	logic                   hresp_ff;
	logic [3:0]             port3_out_ff;
	logic                   comp_power_en_ff;
	logic                   irq_line_one_ff;
	logic                   stop_rec_in3_ff;
	logic                   stop_rec_irq_line_one_ff;
	logic                   stop_rec_comp_en_ff;
	logic                   irq_ff;

	logic [5:0]             sync_lvl;
	logic [5:0]             edge_sel;
	logic [5:0]             edge_hit;
	logic [3:0]             pin_lvl;
	logic [1:0]             comp_lvl;
	logic                   addr_ok;
	logic                   rd_now;
	logic                   status_rd;
	logic [`PCIO_DIN_W-1:0] din_view;
	logic [`PCIO_EVT_W-1:0] evt_set;
	logic [`PCIO_EVT_W-1:0] nxt_status;
	logic [31:0]            nxt_hrdata;
	logic [3:0]             nxt_port3_out;

	if (NUM_IN != 4) begin : g_chk
		$error("pcio_top: the port has exactly four fixed inputs");
	end

	pcio_sync #(
		.WIDTH(6)
	) u_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.async_in({comp_b_result, comp_a_result, port3_in}),
		.sync_out(sync_lvl)
	);

	assign pin_lvl  = sync_lvl[3:0];
	// comparator results mean nothing while unpowered
	assign comp_lvl = comp_power_en_ff ? sync_lvl[5:4] : 2'h0;
	assign edge_sel = {`PCIO_COMP_POL, cfg_ff.edge_pol};

	pcio_edge #(
		.WIDTH(6)
	) u_edge (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.level_in  ({comp_lvl, pin_lvl}),
		.rise_sel  (edge_sel),
		.edge_pulse(edge_hit)
	);

	// analog mode: pin 0 and in3 carry the reference, read back as zero
	always_comb begin
		din_view = {comp_lvl, pin_lvl};
		if (cfg_ff.analog_mode) begin
			din_view[0] = 1'b0;
			din_view[3] = 1'b0;
		end
	end

	always_comb begin
		evt_set = edge_hit;
		// in3 event diverted away from the port interrupt in analog mode
		if (cfg_ff.analog_mode) begin
			evt_set[0] = 1'b0;
			evt_set[3] = 1'b0;
		end else begin
			evt_set[5:4] = 2'h0;
		end
	end

	// bus decode: zero wait states, so the slave is ready in every cycle from the first edge after reset
	assign rd_now    = hsel & hready & htrans[1] & ~hwrite;
	assign addr_ok   = (haddr[1:0] == 2'h0);
	assign status_rd = rd_now & addr_ok & (haddr == `PCIO_OFS_STATUS);

	always_comb begin
		nxt_hrdata = 32'h0000_0000;
		if (rd_now && addr_ok) begin
			case (haddr)
				`PCIO_OFS_DATA_OUT: nxt_hrdata[7:4] = data_out_ff;
				`PCIO_OFS_DATA_IN:  nxt_hrdata[`PCIO_DIN_W-1:0] = din_view;
				`PCIO_OFS_CFG:      nxt_hrdata[`PCIO_CFG_W-1:0] = cfg_ff;
				`PCIO_OFS_STATUS:   nxt_hrdata[`PCIO_EVT_W-1:0] = status_ff;
				`PCIO_OFS_MASK:     nxt_hrdata[`PCIO_EVT_W-1:0] = mask_ff;
				default:            nxt_hrdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acc_ff <= '0;
		end else if (hready) begin
			acc_ff.wr  <= hsel & htrans[1] & hwrite & addr_ok;
			acc_ff.rd  <= rd_now;
			acc_ff.ofs <= haddr;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_ff <= 32'h0000_0000;
		end else begin
			hrdata_ff <= nxt_hrdata;
		end
	end

	// ready only once out of reset; no wait states afterwards
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout_ff <= 1'b0;
		end else begin
			hreadyout_ff <= 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp_ff <= 1'b0;
		end else begin
			hresp_ff <= 1'b0;
		end
	end

	// config written in data phase, acts from the following edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_ff <= pcio_cfg_s'(`PCIO_RST_CFG);
		end else if (acc_ff.wr && acc_ff.ofs == `PCIO_OFS_CFG) begin
			cfg_ff <= pcio_cfg_s'(hwdata[`PCIO_CFG_W-1:0]);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			data_out_ff <= `PCIO_RST_DATA_OUT;
		end else if (acc_ff.wr && acc_ff.ofs == `PCIO_OFS_DATA_OUT) begin
			data_out_ff <= hwdata[7:4];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mask_ff <= `PCIO_RST_MASK;
		end else if (acc_ff.wr && acc_ff.ofs == `PCIO_OFS_MASK) begin
			mask_ff <= hwdata[`PCIO_EVT_W-1:0];
		end
	end

	// read clears, but an event in the same cycle survives
	assign nxt_status = (status_rd ? '0 : status_ff) | evt_set;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_ff <= '0;
		end else begin
			status_ff <= nxt_status;
		end
	end

	// level interrupt tracks the status value of the same edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(nxt_status & mask_ff);
		end
	end

	for (genvar i = 0; i < 4; i++) begin : g_out
		logic steer;
		logic steer_val;
		// comparator steering wins over timer and data
		if (i == 0) begin : g_comp_a
			assign steer     = cfg_ff.comp_a_out4;
			assign steer_val = comp_lvl[0];
		end else if (i == 3) begin : g_comp_b
			assign steer     = cfg_ff.comp_b_out7;
			assign steer_val = comp_lvl[1];
		end else begin : g_plain
			assign steer     = 1'b0;
			assign steer_val = 1'b0;
		end
		assign nxt_port3_out[i] = steer ? steer_val
		                        : (cfg_ff.timer_sel[i] ? timer_out[i] : data_out_ff[i]);
	end

	// outputs always driven, never turned to inputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port3_out_ff <= 4'h0;
		end else begin
			port3_out_ff <= nxt_port3_out;
		end
	end

	// comparators off in stop mode or digital mode
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			comp_power_en_ff <= 1'b0;
		end else begin
			comp_power_en_ff <= cfg_ff.analog_mode & ~stop_mode;
		end
	end

	// digital mode in3 edge raises irq_line_one
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_line_one_ff <= 1'b0;
		end else begin
			irq_line_one_ff <= ~cfg_ff.analog_mode & edge_hit[3];
		end
	end

	// analog mode: in3 latch and its interrupt feed stop recovery
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stop_rec_in3_ff <= 1'b0;
		end else begin
			stop_rec_in3_ff <= cfg_ff.analog_mode & pin_lvl[3];
		end
	end

	// in3 edge pulse for the recovery logic, analog mode only
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stop_rec_irq_line_one_ff <= 1'b0;
		end else begin
			stop_rec_irq_line_one_ff <= cfg_ff.analog_mode & edge_hit[3];
		end
	end

	// comparator pins count as recovery sources only in digital mode
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stop_rec_comp_en_ff <= 1'b1;
		end else begin
			stop_rec_comp_en_ff <= ~cfg_ff.analog_mode;
		end
	end

	assign hrdata           = hrdata_ff;
	assign hreadyout        = hreadyout_ff;
	assign hresp            = hresp_ff;
	assign port3_out        = port3_out_ff;
	assign comp_power_en    = comp_power_en_ff;
	assign irq_line_one     = irq_line_one_ff;
	assign stop_rec_in3     = stop_rec_in3_ff;
	assign stop_rec_irq_line_one    = stop_rec_irq_line_one_ff;
	assign stop_rec_comp_en = stop_rec_comp_en_ff;
	assign irq              = irq_ff;

	// the aux reference pin is analog only; no digital logic samples it
	logic unused_ok;
	assign unused_ok = reference_pin_aux ^ hsize[0] ^ (^hsize[2:1]);
endmodule
`default_nettype wire

// file: pkg/pcio_consts.svh
// register offsets, field positions and reset values of the port 3 block
`ifndef PCIO_CONSTS_SVH
`define PCIO_CONSTS_SVH

`define PCIO_OFS_DATA_OUT   8'h00
`define PCIO_OFS_DATA_IN    8'h04
`define PCIO_OFS_CFG        8'h08
`define PCIO_OFS_STATUS     8'h0c
`define PCIO_OFS_MASK       8'h10

`define PCIO_CFG_ANALOG     0
`define PCIO_CFG_COMPA_OUT4 1
`define PCIO_CFG_COMPB_OUT7 2
`define PCIO_CFG_TSEL_LO    3
`define PCIO_CFG_POL_LO     7
`define PCIO_CFG_W          11

`define PCIO_EVT_W          6
`define PCIO_DIN_W          6

`define PCIO_RST_DATA_OUT   4'h0
`define PCIO_RST_CFG        11'h000
`define PCIO_RST_MASK       6'h00
`define PCIO_COMP_POL       2'h3

`endif

// file: pkg/pcio_pkg.sv
// types shared by the port 3 block
`default_nettype none
package pcio_pkg;
	`include "pcio_consts.svh"

	// port_config_reg layout, msb first
	typedef struct packed {
		logic [3:0] edge_pol;
		logic [3:0] timer_sel;
		logic       comp_b_out7;
		logic       comp_a_out4;
		logic       analog_mode;
	} pcio_cfg_s;

	typedef enum logic [1:0] {
		PCIO_HTRANS_IDLE   = 2'h0,
		PCIO_HTRANS_BUSY   = 2'h1,
		PCIO_HTRANS_NONSEQ = 2'h2,
		PCIO_HTRANS_SEQ    = 2'h3
	} pcio_htrans_e;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] ofs;
	} pcio_acc_s;
endpackage
`default_nettype wire

// file: hdl/pcio_sync.sv
// two flip-flop synchroniser bank
`default_nettype none
module pcio_sync #(
	parameter int WIDTH = 6
) (
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	import pcio_pkg::*;

	logic [WIDTH-1:0] meta_ff;

	if (WIDTH < 1) begin : g_chk
		$error("pcio_sync: WIDTH must be at least 1");
	end

	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		// first stage feeds only the second stage
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				meta_ff[i]  <= 1'b0;
				sync_out[i] <= 1'b0;
			end else begin
				meta_ff[i]  <= async_in[i];
				sync_out[i] <= meta_ff[i];
			end
		end
	end
endmodule
`default_nettype wire

// file: hdl/pcio_edge.sv
// per-bit edge detector with selectable polarity
`default_nettype none
module pcio_edge #(
	parameter int WIDTH = 6
) (
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic [WIDTH-1:0] level_in,
	input  wire logic [WIDTH-1:0] rise_sel,
	output logic      [WIDTH-1:0] edge_pulse
);
	import pcio_pkg::*;

	logic [WIDTH-1:0] prev_ff;

	if (WIDTH < 1) begin : g_chk
		$error("pcio_edge: WIDTH must be at least 1");
	end

	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				prev_ff[i] <= 1'b0;
			end else begin
				prev_ff[i] <= level_in[i];
			end
		end
		// rise_sel high picks the rising edge, low the falling edge
		assign edge_pulse[i] = rise_sel[i] ? (level_in[i] & ~prev_ff[i])
		                                   : (~level_in[i] & prev_ff[i]);
	end
endmodule
`default_nettype wire

// file: dv/pcio_monitor.sv
// port-level assertions for the port 3 block
`default_nettype none
module pcio_monitor (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic stop_mode,
	input wire logic comp_power_en,
	input wire logic irq_line_one,
	input wire logic stop_rec_in3,
	input wire logic stop_rec_irq_line_one,
	input wire logic stop_rec_comp_en
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	property p_ready;
		$past(hresetn) |-> hreadyout && !hresp;
	endproperty
	a_ready: assert property (p_ready) else $error("bus not ready");
	property p_stop_pwr;
		stop_mode |=> !comp_power_en;
	endproperty
	a_stop_pwr: assert property (p_stop_pwr) else $error("comparator powered in stop");
	property p_stop_hold;
		stop_mode [*2] |-> !comp_power_en;
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("power back in stop");
	property p_pwr_mode;
		comp_power_en |-> !stop_rec_comp_en;
	endproperty
	a_pwr_mode: assert property (p_pwr_mode) else $error("power in digital");
	property p_irq_line_one_pulse;
		irq_line_one |=> !irq_line_one;
	endproperty
	a_irq_line_one_pulse: assert property (p_irq_line_one_pulse) else $error("irq pulse long");
	property p_an_irq_line_one;
		!stop_rec_comp_en |-> !irq_line_one;
	endproperty
	a_an_irq_line_one: assert property (p_an_irq_line_one) else $error("irq in analog");
	property p_dig_rec;
		stop_rec_comp_en |-> !stop_rec_in3 && !stop_rec_irq_line_one;
	endproperty
	a_dig_rec: assert property (p_dig_rec) else $error("recovery in digital");
	property p_rec_pulse;
		$rose(stop_rec_irq_line_one) |=> $fell(stop_rec_irq_line_one);
	endproperty
	a_rec_pulse: assert property (p_rec_pulse) else $error("recovery pulse long");
endmodule
bind pcio_top pcio_monitor i_mon (.hclk, .hresetn, .hreadyout, .hresp, .stop_mode,
	.comp_power_en, .irq_line_one, .stop_rec_in3, .stop_rec_irq_line_one, .stop_rec_comp_en);
`default_nettype wire

// file: dv/pcio_partner.sv
// model of board pins, comparator front end and counter/timers
`default_nettype none
module pcio_partner (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic [3:0] pins,
	input  wire logic [3:0] lvl_a,
	input  wire logic [3:0] lvl_b,
	input  wire logic [3:0] lvl_ref,
	output logic      [3:0] port3_in,
	output logic            reference_pin_aux,
	output logic            comp_a_result,
	output logic            comp_b_result,
	output logic      [3:0] timer_out
);
	timeunit 1ns;
	timeprecision 1ps;
	assign port3_in = pins;
	assign reference_pin_aux = lvl_ref[3];
	assign comp_a_result = lvl_a > lvl_ref;
	assign comp_b_result = lvl_b > lvl_ref;
	// counter keeps moving so a stuck output shows
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			timer_out <= 4'h0;
		else
			timer_out <= timer_out + 4'h1;
endmodule
`default_nettype wire

// file: dv/tb_port3_comparator_io.sv
// self-checking bench for the port 3 block
`default_nettype none
`include "pcio_consts.svh"
module tb_port3_comparator_io;
	timeunit 1ns;
	timeprecision 1ps;
	import pcio_pkg::*;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0, stop_mode = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0, hrdata, rd;
	logic [3:0] pins = 4'h0, lvl_a = 4'h0, lvl_b = 4'h0, lvl_ref = 4'h8;
	logic [3:0] port3_in, timer_out, port3_out;
	logic hready, hreadyout, hresp, reference_pin_aux, comp_a_result, comp_b_result;
	logic comp_power_en, irq_line_one, stop_rec_in3, stop_rec_irq_line_one, stop_rec_comp_en, irq;
	int err_total = 0, n_compared = 0, cyc = 0, n_rec = 0, n_irq_line_one = 0;
	assign hready = hreadyout;
	always #20 hclk = ~hclk;
	pcio_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hrdata, .hreadyout, .hresp, .port3_in, .reference_pin_aux,
		.comp_a_result, .comp_b_result, .stop_mode, .timer_out, .port3_out,
		.comp_power_en, .irq_line_one, .stop_rec_in3, .stop_rec_irq_line_one,
		.stop_rec_comp_en, .irq);
	pcio_partner i_far (.hclk, .hresetn, .pins, .lvl_a, .lvl_b, .lvl_ref, .port3_in,
		.reference_pin_aux, .comp_a_result, .comp_b_result, .timer_out);
	// pulses stand one cycle, so the falling edge sees each once
	always @(negedge hclk) begin
		n_irq_line_one += int'(irq_line_one === 1'b1);
		n_rec += int'(stop_rec_irq_line_one === 1'b1);
	end
	task automatic complete_run;
		if (err_total == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			complete_run;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		haddr <= a;
		hwrite <= w;
		htrans <= PCIO_HTRANS_NONSEQ;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= PCIO_HTRANS_IDLE;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task automatic t_regs;
		bus(0, `PCIO_OFS_CFG, 0);
		chk(rd, 0);
		bus(0, `PCIO_OFS_MASK, 0);
		chk(rd, 0);
		bus(0, 8'h14, 0);
		chk(rd, 0);
		bus(1, `PCIO_OFS_DATA_OUT, 32'ha0);
		bus(1, `PCIO_OFS_DATA_IN, 32'hff);
		chk({28'h0, port3_out}, 32'ha);
		bus(1, 8'h01, 32'h50);
		bus(0, `PCIO_OFS_DATA_OUT, 0);
		chk(rd, 32'ha0);
		bus(0, `PCIO_OFS_DATA_IN, 0);
		chk(rd, 0);
	endtask
	task automatic t_timer;
		bus(1, `PCIO_OFS_CFG, 32'h78);
		repeat (2) @(negedge hclk);
		chk({28'h0, port3_out}, {28'h0, timer_out - 4'h1});
		@(posedge hclk);
	endtask
	task automatic t_irq;
		bus(1, `PCIO_OFS_MASK, 32'h08);
		bus(1, `PCIO_OFS_CFG, 32'h400);
		pins <= 4'h8;
		repeat (6) @(posedge hclk);
		chk(32'(n_irq_line_one), 1);
		chk({31'h0, irq}, 1);
		bus(0, `PCIO_OFS_STATUS, 0);
		chk(rd, 32'h08);
		bus(0, `PCIO_OFS_DATA_IN, 0);
		chk(rd, 32'h08);
		chk({31'h0, irq}, 0);
		bus(1, `PCIO_OFS_MASK, 0);
		bus(1, `PCIO_OFS_CFG, 0);
		pins <= 4'h0;
		repeat (6) @(posedge hclk);
		chk({31'h0, irq}, 0);
		bus(0, `PCIO_OFS_STATUS, 0);
		chk(rd, 32'h08);
		pins <= 4'h8;
	endtask
	task automatic t_analog;
		lvl_a <= 4'hc;
		bus(1, `PCIO_OFS_CFG, 32'h7);
		repeat (6) @(posedge hclk);
		chk({28'h0, port3_out}, 32'h3);
		bus(0, `PCIO_OFS_STATUS, 0);
		chk(rd, 32'h10);
		bus(0, `PCIO_OFS_DATA_IN, 0);
		chk(rd, 32'h10);
		chk({31'h0, stop_rec_in3}, 1);
		pins <= 4'h0;
		repeat (6) @(posedge hclk);
		chk(32'(n_rec), 1);
		chk(32'(n_irq_line_one), 2);
		bus(0, `PCIO_OFS_STATUS, 0);
		chk(rd, 0);
		stop_mode <= 1'b1;
		repeat (3) @(posedge hclk);
		chk({31'h0, comp_power_en}, 0);
		bus(0, `PCIO_OFS_DATA_IN, 0);
		chk(rd, 0);
		stop_mode <= 1'b0;
		bus(1, `PCIO_OFS_CFG, 0);
		repeat (2) @(posedge hclk);
		chk({31'h0, stop_rec_comp_en}, 1);
	endtask
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		t_regs;
		t_timer;
		t_irq;
		t_analog;
		complete_run;
	end
endmodule
`default_nettype wire
